/* design/gdr_bank.sv */
// gamma reference register bank: serial slave port, working and backing bytes
// assumes scl/sda/strap arrive asynchronously; sda is open drain outside
`timescale 1ns/10ps
`default_nettype none
module gdr_bank
	import gdr_pkg::*;
#(
	parameter int unsigned NV_WRITE_CYCLES = NV_WRITE_CYCLES_DFLT
) (
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       sys_rst_i,
	// serial port pins
	input  wire logic                       scl_i,
	input  wire logic                       sda_i,
	output logic                            sda_o,
	output logic                            sda_oe_n_o,
	// address strap
	input  wire logic                       address_strap_pin_i,
	// DAC codes
	output logic [HIGH_CH*CODE_W-1:0]       high_side_gamma_outputs_o,
	output logic [HIGH_CH*CODE_W-1:0]       low_side_gamma_outputs_o,
	output logic                            dac_valid_o,
	// status
	output logic                            nv_busy_o
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	gdr_state_e               state;
	logic                     scl_s;
	logic                     sda_s;
	logic                     strap_s;
	logic                     scl_q;
	logic                     sda_q;
	logic [3:0]               bit_cnt;
	logic [7:0]               rx_sh;
	logic [7:0]               tx_sh;
	logic [7:0]               ptr;
	logic                     rw_q;
	logic                     nack_q;
	logic                     mode;
	logic [CODE_W-1:0]        working [NUM_CH];
	logic [CODE_W-1:0]        dac     [NUM_CH];
	logic [NUM_CH-1:0]        pend_mask;
	logic [NUM_CH*CODE_W-1:0] pend_data;
	logic                     loading;
	logic [2:0]               load_idx;
	logic [CODE_W-1:0]        nv_rd;
	logic                     active;
	logic                     start_evt;
	logic                     stop_evt;
	logic                     scl_rise;
	logic                     scl_fall;
	logic                     byte_done;
	logic                     ack_end;
	logic                     addr_match;
	logic                     wr_evt;
	logic                     wr_ch_evt;
	logic                     wr_ctrl_evt;
	logic                     nv_start;
	logic [7:0]               rd_byte;

	// ----------------------------------------------------------------
	// pin synchronisers; 40 MHz gives ample samples per 400kHz bit
	// ----------------------------------------------------------------
	gdr_pin_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i    ({scl_i, sda_i, address_strap_pin_i}),
		.level_o  ({scl_s, sda_s, strap_s})
	);

	// previous filtered levels for edge and condition detection
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// bus events and byte milestones
	assign start_evt   = scl_s && scl_q && sda_q && !sda_s;
	assign stop_evt    = scl_s && scl_q && !sda_q && sda_s;
	assign scl_rise    = scl_s && !scl_q;
	assign scl_fall    = !scl_s && scl_q;
	assign active      = (state != ST_IDLE) && (state != ST_IGNORE);
	assign byte_done   = active && scl_fall && (bit_cnt == ACK_SLOT_CNT);
	assign ack_end     = active && scl_fall && (bit_cnt == ACK_END_CNT);
	assign addr_match  = (rx_sh[7:1] == (SLAVE_BASE | {6'h00, strap_s}));
	assign wr_evt      = byte_done && (state == ST_WDATA);
	assign wr_ch_evt   = wr_evt && (ptr <= CH_LAST_ADDR);
	assign wr_ctrl_evt = wr_evt && (ptr == CTRL_ADDR);
	assign nv_start    = stop_evt && (pend_mask != '0) && !nv_busy_o;

	// read data: working byte for channels, mode alone for control, zero elsewhere
	always_comb begin
		if (ptr <= CH_LAST_ADDR) begin
			rd_byte = working[ptr[2:0]];
		end else if (ptr == CTRL_ADDR) begin
			rd_byte = {mode, 7'h00};
		end else begin
			rd_byte = RESERVED_READ;
		end
	end

	// ----------------------------------------------------------------
	// protocol state, bit count and data line
	// ----------------------------------------------------------------
	// sda is only ever pulled low; sda_oe_n_o low means pulling
	assign sda_o = 1'b0;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state      <= ST_IDLE;
			bit_cnt    <= 4'h0;
			sda_oe_n_o <= 1'b1;
			tx_sh      <= 8'h00;
			rw_q       <= 1'b0;
			nack_q     <= 1'b0;
		end else if (loading) begin
			state <= ST_IDLE;
		end else if (start_evt) begin
			state      <= ST_ADDR;
			bit_cnt    <= 4'h0;
			sda_oe_n_o <= 1'b1;
		end else if (stop_evt) begin
			state      <= ST_IDLE;
			sda_oe_n_o <= 1'b1;
		end else if (active && scl_rise) begin
			bit_cnt <= bit_cnt + 4'h1;
			if (state == ST_RDATA && bit_cnt == ACK_SLOT_CNT) begin
				nack_q <= sda_s;
			end
		end else if (byte_done) begin
			case (state)
				ST_ADDR: begin
					// busy backing store refuses its address like a real part
					if (addr_match && !nv_busy_o) begin
						sda_oe_n_o <= 1'b0;
						rw_q       <= rx_sh[0];
					end else begin
						state <= ST_IGNORE;
					end
				end
				ST_REG, ST_WDATA: sda_oe_n_o <= 1'b0;
				default: sda_oe_n_o <= 1'b1;
			endcase
		end else if (ack_end) begin
			bit_cnt    <= 4'h0;
			sda_oe_n_o <= 1'b1;
			case (state)
				ST_ADDR: begin
					state <= rw_q ? ST_RDATA : ST_REG;
					if (rw_q) begin
						tx_sh      <= {rd_byte[6:0], 1'b0};
						sda_oe_n_o <= rd_byte[7];
					end
				end
				ST_REG: state <= ST_WDATA;
				ST_RDATA: begin
					// master NACK ends the read; wait for STOP or START
					if (nack_q) begin
						state <= ST_IGNORE;
					end else begin
						tx_sh      <= {rd_byte[6:0], 1'b0};
						sda_oe_n_o <= rd_byte[7];
					end
				end
				default: state <= state;
			endcase
		end else if (active && scl_fall && state == ST_RDATA) begin
			tx_sh      <= {tx_sh[6:0], 1'b0};
			sda_oe_n_o <= tx_sh[7];
		end
	end

	// incoming byte shifter, msb first on rising scl
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_sh <= 8'h00;
		end else if (active && scl_rise && bit_cnt < ACK_SLOT_CNT) begin
			rx_sh <= {rx_sh[6:0], sda_s};
		end
	end

	// register pointer: loaded from the second byte, then auto-increments
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ptr <= CH_FIRST_ADDR;
		end else if (byte_done && state == ST_REG) begin
			ptr <= rx_sh;
		end else if (byte_done && state == ST_RDATA) begin
			ptr <= ptr + 8'h01;
		end else if (ack_end && state == ST_WDATA) begin
			ptr <= ptr + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mode <= CTRL_MODE_RST;
		end else if (wr_ctrl_evt) begin
			mode <= rx_sh[MODE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// backing store and power-up load
	// ----------------------------------------------------------------
	gdr_nv_store #(.WRITE_CYCLES(NV_WRITE_CYCLES)) u_nv (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.prog_start_i(nv_start),
		.prog_mask_i (pend_mask),
		.prog_data_i (pend_data),
		.busy_o      (nv_busy_o),
		.rd_idx_i    (load_idx),
		.rd_data_o   (nv_rd)
	);

	// walk all eight backing bytes once, then release the DAC outputs
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			loading     <= 1'b1;
			load_idx    <= 3'h0;
			dac_valid_o <= 1'b0;
		end else if (loading) begin
			load_idx <= load_idx + 3'h1;
			if (load_idx == 3'h7) begin
				loading     <= 1'b0;
				dac_valid_o <= 1'b1;
			end
		end
	end

	// pending programming collects mode-0 channel writes until STOP
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pend_mask <= '0;
			pend_data <= '0;
		end else if (stop_evt) begin
			pend_mask <= '0;
		end else if (wr_ch_evt && !mode) begin
			pend_mask[ptr[2:0]]                  <= 1'b1;
			pend_data[ptr[2:0]*CODE_W +: CODE_W] <= rx_sh;
		end
	end

	// ----------------------------------------------------------------
	// per-channel working byte and DAC code
	// ----------------------------------------------------------------
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		// working byte: loaded at power-up, written in either mode
		always_ff @(posedge clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				working[c] <= 8'h00;
			end else if (loading && load_idx == 3'(c)) begin
				working[c] <= nv_rd;
			end else if (wr_ch_evt && ptr[2:0] == 3'(c)) begin
				working[c] <= rx_sh;
			end
		end
		// DAC code follows the working byte only at STOP, so a partly written
		// multi-byte update never shows on the outputs
		always_ff @(posedge clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				dac[c] <= 8'h00;
			end else if (loading && load_idx == 3'(c)) begin
				dac[c] <= nv_rd;
			end else if (stop_evt) begin
				dac[c] <= working[c];
			end
		end
		// code n is tap n of 255; first four face the high pair
		if (c < HIGH_CH) begin : g_hi
			assign high_side_gamma_outputs_o[c*CODE_W +: CODE_W] = dac[c];
		end else begin : g_lo
			assign low_side_gamma_outputs_o[(c-HIGH_CH)*CODE_W +: CODE_W] = dac[c];
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_stop_with_pending;
		stop_evt ##0 (pend_mask != '0) ##0 !nv_busy_o;
	endsequence

	property p_nv_after_stop;
		$rose(nv_busy_o) |-> $past(stop_evt);
	endproperty
	a_nv_after_stop: assert property (p_nv_after_stop) else $error("programming without stop");

	property p_nv_launch;
		s_stop_with_pending |=> nv_busy_o;
	endproperty
	a_nv_launch: assert property (p_nv_launch) else $error("pending write not programmed");

	property p_dac_on_stop;
		(dac_valid_o && !$stable(high_side_gamma_outputs_o)) |-> $past(stop_evt);
	endproperty
	a_dac_on_stop: assert property (p_dac_on_stop) else $error("dac code moved without stop");

	property p_mode1_no_pend;
		(wr_ch_evt && mode) |=> (pend_mask == $past(pend_mask));
	endproperty
	a_mode1_no_pend: assert property (p_mode1_no_pend) else $error("mode 1 queued programming");

	property p_mode0_pend;
		(wr_ch_evt && !mode) |=> pend_mask[$past(ptr[2:0])];
	endproperty
	a_mode0_pend: assert property (p_mode0_pend) else $error("mode 0 write not queued");

	property p_mode_keeps_data;
		!$stable(mode) |-> ($stable(pend_mask) && !$past(wr_ch_evt));
	endproperty
	a_mode_keeps_data: assert property (p_mode_keeps_data) else $error("mode change hit data");

	property p_ctrl_no_pend;
		wr_ctrl_evt |=> (pend_mask == $past(pend_mask));
	endproperty
	a_ctrl_no_pend: assert property (p_ctrl_no_pend) else $error("control write queued programming");

	property p_load_mode0;
		loading |-> (!mode && !dac_valid_o && state == ST_IDLE);
	endproperty
	a_load_mode0: assert property (p_load_mode0) else $error("bad state during power-up load");

	property p_load_len;
		$fell(loading) |-> ($past(loading, 8) || $past(sys_rst_i, 8)) && dac_valid_o;
	endproperty
	a_load_len: assert property (p_load_len) else $error("power-up load length wrong");

	property p_ignore_holds;
		(state == ST_IGNORE && !start_evt && !stop_evt) |=> (state == ST_IGNORE && sda_oe_n_o);
	endproperty
	a_ignore_holds: assert property (p_ignore_holds) else $error("ignored transfer touched bus");

	property p_addr_ack;
		(state == ST_ADDR && byte_done) ##1 !sda_oe_n_o |-> $past(addr_match);
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("acked wrong address");

	property p_open_drain;
		!sda_oe_n_o |-> (sda_o == 1'b0) && (state != ST_IDLE) && (state != ST_IGNORE);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("sda driven out of transfer");

endmodule
`default_nettype wire

/* design/gdr_pkg.sv */
// package for the gamma reference register bank
// assumes a single 40 MHz system clock; gdr_bank, gdr_nv_store and tb_top import it whole
package gdr_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ      = 40_000_000;
	localparam int unsigned NV_WRITE_TIME_MS = 20;
	// longest programming time, rounded down to whole cycles
	localparam int unsigned NV_WRITE_CYCLES_DFLT = CLK_FREQ_HZ / 1000 * NV_WRITE_TIME_MS;

	// ----------------------------------------------------------------
	// channel layout
	// ----------------------------------------------------------------
	localparam int unsigned NUM_CH  = 8;
	localparam int unsigned CODE_W  = 8;
	localparam int unsigned HIGH_CH = 4;
	localparam logic [7:0] NV_FACTORY_VAL = 8'h80;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_FIRST_ADDR  = 8'h00;
	localparam logic [7:0] CH_LAST_ADDR   = 8'h07;
	localparam logic [7:0] CTRL_ADDR      = 8'h08;
	localparam int unsigned MODE_BIT      = 7;
	localparam logic       CTRL_MODE_RST  = 1'b0;
	localparam logic [7:0] RESERVED_READ  = 8'h00;

	// ----------------------------------------------------------------
	// serial port
	// ----------------------------------------------------------------
	localparam logic [6:0] SLAVE_BASE     = 7'h74;
	localparam logic [3:0] ACK_SLOT_CNT   = 4'h8;
	localparam logic [3:0] ACK_END_CNT    = 4'h9;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_ADDR   = 3'h1,
		ST_REG    = 3'h3,
		ST_WDATA  = 3'h2,
		ST_RDATA  = 3'h6,
		ST_IGNORE = 3'h4
	} gdr_state_e;

endpackage

/* design/gdr_pin_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
// assumes inputs are asynchronous to clk_i; output changes once stages 2 and 3 agree
`timescale 1ns/10ps
`default_nettype none
module gdr_pin_sync #(
	parameter int unsigned W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	// pins in, filtered levels out
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// ----------------------------------------------------------------
	// capture chain; stage1 feeds only stage2
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stage1 <= RST_VAL;
			stage2 <= RST_VAL;
			stage3 <= RST_VAL;
		end else begin
			stage1 <= pin_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a bit moves only when the two late stages agree, rejecting one-sample glitches
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			level_o <= RST_VAL;
		end else begin
			level_o <= ((stage2 ~^ stage3) & stage3) | ((stage2 ^ stage3) & level_o);
		end
	end

endmodule
`default_nettype wire

/* design/gdr_nv_store.sv */
// nonvolatile backing bytes with a timed programming cycle
// assumes the caller starts a cycle only while busy_o is low
`timescale 1ns/10ps
`default_nettype none
module gdr_nv_store
	import gdr_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = NV_WRITE_CYCLES_DFLT
) (
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       sys_rst_i,
	// programming request
	input  wire logic                       prog_start_i,
	input  wire logic [NUM_CH-1:0]          prog_mask_i,
	input  wire logic [NUM_CH*CODE_W-1:0]   prog_data_i,
	output logic                            busy_o,
	// read port
	input  wire logic [2:0]                 rd_idx_i,
	output logic      [CODE_W-1:0]          rd_data_o
);

	logic [CODE_W-1:0]        cells [NUM_CH];
	logic [NUM_CH-1:0]        mask_q;
	logic [NUM_CH*CODE_W-1:0] data_q;
	logic [31:0]              timer;

	assign rd_data_o = cells[rd_idx_i];

	// ----------------------------------------------------------------
	// programming timer; cells commit only when the full time has run
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy_o <= 1'b0;
			timer  <= 32'h0;
			mask_q <= '0;
			data_q <= '0;
		end else if (prog_start_i && !busy_o) begin
			busy_o <= 1'b1;
			timer  <= WRITE_CYCLES - 1;
			mask_q <= prog_mask_i;
			data_q <= prog_data_i;
		end else if (busy_o) begin
			if (timer == 32'h0) begin
				busy_o <= 1'b0;
			end else begin
				timer <= timer - 32'h1;
			end
		end
	end

	// cells hold the factory value until first programmed
	// limitation: simulation reset restores that value, a real array would not
	for (genvar c = 0; c < NUM_CH; c++) begin : g_cell
		always_ff @(posedge clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				cells[c] <= NV_FACTORY_VAL;
			end else if (busy_o && timer == 32'h0 && mask_q[c]) begin
				cells[c] <= data_q[c*CODE_W +: CODE_W];
			end
		end
	end

endmodule
`default_nettype wire

/* bench/gdr_bus_master.sv */
// partner model: serial bus master driving clock and open-drain data
// assumes the bench resolves the data wire with a pull-up and feeds it back
`timescale 1ns/10ps
`default_nettype none
module gdr_bus_master #(
	parameter int Q = 26
) (
	// clock
	input  wire logic clk_i,
	// bus pins
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_n_o
);
	// ------------------------------------------------------------
	// bus phases
	// ------------------------------------------------------------
	// both lines idle high between frames
	initial begin
		scl_o = 1'h1;
		sda_oe_n_o = 1'h1;
	end
	// four quarters of 26 clocks keep the bit rate below 400kHz
	task automatic hold(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// also serves as repeated start: data falls while clock high
	task automatic start();
		sda_oe_n_o = 1'h1;
		hold(Q);
		scl_o = 1'h1;
		hold(2 * Q);
		sda_oe_n_o = 1'h0;
		hold(2 * Q);
		scl_o = 1'h0;
		hold(Q);
	endtask
	// data rises while clock high
	task automatic stop();
		sda_oe_n_o = 1'h0;
		hold(Q);
		scl_o = 1'h1;
		hold(2 * Q);
		sda_oe_n_o = 1'h1;
		hold(Q);
	endtask
	// data only changes while clock is low, sampled in the high phase
	task automatic bit_io(input logic b, output logic r);
		sda_oe_n_o = b;
		hold(Q);
		scl_o = 1'h1;
		hold(Q);
		r = sda_i;
		hold(Q);
		scl_o = 1'h0;
		hold(Q);
	endtask
	// msb first, then release for the slave's answer
	task automatic wbyte(input logic [7:0] d, output logic nak);
		for (int i = 7; i >= 0; i--) bit_io(d[i], nak);
		bit_io(1'h1, nak);
	endtask
	// last byte is refused so the slave lets go of the data line
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'h1, b);
			d[i] = b;
		end
		bit_io(last, b);
	endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the gamma register bank
// assumes the bus master model drives scl and shares the pulled-up data wire
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import gdr_pkg::*;
	// short programming time, still longer than one address byte
	localparam int NVC = 1500;
	logic        clk;
	logic        rst;
	logic        strap;
	logic        scl;
	logic        m_oe_n;
	logic        d_sda;
	logic        d_oe_n;
	logic        sda_w;
	logic [31:0] hi;
	logic [31:0] lo;
	logic        valid;
	logic        busy;
	logic        mode;
	logic [7:0]  exp [8];
	int          errors;
	int          n_checks;
	// ------------------------------------------------------------
	// wiring
	// ------------------------------------------------------------
	assign sda_w = m_oe_n & (d_oe_n | d_sda);
	// every device pin follows a bench signal, so strap and bus lines are all exercised
	gdr_bank #(
		.NV_WRITE_CYCLES(NVC)
	) u_dut (
		.clk_i                    (clk),
		.sys_rst_i                (rst),
		.scl_i                    (scl),
		.sda_i                    (sda_w),
		.sda_o                    (d_sda),
		.sda_oe_n_o               (d_oe_n),
		.address_strap_pin_i      (strap),
		.high_side_gamma_outputs_o(hi),
		.low_side_gamma_outputs_o (lo),
		.dac_valid_o              (valid),
		.nv_busy_o                (busy)
	);
	gdr_bus_master u_m (
		.clk_i     (clk),
		.sda_i     (sda_w),
		.scl_o     (scl),
		.sda_oe_n_o(m_oe_n)
	);
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] want_v);
		n_checks = n_checks + 1;
		if (seen !== want_v) begin
			errors = errors + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, want_v);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic [7:0] dev(input logic rd);
		return 8'hE8 | {6'h00, strap, rd};
	endfunction
	function automatic logic [7:0] want(input logic [7:0] a);
		if (a < 8'h08) return exp[a[2:0]];
		if (a == 8'h08) return {mode, 7'h00};
		return 8'h00;
	endfunction
	task automatic chk_dac();
		chk(hi, {exp[3], exp[2], exp[1], exp[0]});
		chk(lo, {exp[7], exp[6], exp[5], exp[4]});
	endtask
	// address byte, register address second, one data byte
	task automatic wr(input logic [7:0] sa, input logic [7:0] a, input logic [7:0] d,
			input logic nak_exp, input logic do_stop);
		logic k;
		u_m.start();
		u_m.wbyte(sa, k);
		chk(k, nak_exp);
		u_m.wbyte(a, k);
		chk(k, nak_exp);
		u_m.wbyte(d, k);
		chk(k, nak_exp);
		if (do_stop) u_m.stop();
	endtask
	// pointer set by a write, then repeated start and a burst read
	task automatic rd(input logic [7:0] a, input int n);
		logic       k;
		logic [7:0] q;
		u_m.start();
		u_m.wbyte(dev(1'h0), k);
		u_m.wbyte(a, k);
		u_m.start();
		u_m.wbyte(dev(1'h1), k);
		chk(k, 1'h0);
		for (int i = 0; i < n; i++) begin
			u_m.rbyte(i == n - 1, q);
			chk(q, want(a + 8'(i)));
		end
		u_m.stop();
	endtask
	// the device may only ever pull the data line low
	always @(negedge clk) if (!rst && d_oe_n !== 1'h1) chk(d_sda, 1'h0);
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_power();
		for (int i = 0; i < 100 && valid !== 1'h1; i++) @(negedge clk);
		chk(valid, 1'h1);
		u_m.hold(20);
		chk_dac();
		rd(8'h08, 1);
	endtask
	task automatic t_mode0();
		logic k;
		wr(dev(1'h0), 8'h02, 8'h3C, 1'h0, 1'h0);
		chk_dac();
		chk(busy, 1'h0);
		u_m.stop();
		exp[2] = 8'h3C;
		u_m.hold(10);
		chk(busy, 1'h1);
		chk_dac();
		u_m.start();
		u_m.wbyte(dev(1'h0), k);
		chk(k, 1'h1);
		u_m.stop();
		for (int i = 0; i < 3000 && busy !== 1'h0; i++) @(negedge clk);
		chk(busy, 1'h0);
	endtask
	task automatic t_ctrl();
		wr(dev(1'h0), 8'h08, 8'hFF, 1'h0, 1'h1);
		mode = 1'h1;
		u_m.hold(10);
		chk(busy, 1'h0);
		chk_dac();
		rd(8'h06, 4);
	endtask
	task automatic t_burst();
		logic       k;
		logic [7:0] codes [8] = '{8'h00, 8'hFF, 8'h01, 8'hFE, 8'h7F, 8'h80, 8'h55, 8'hAA};
		u_m.start();
		u_m.wbyte(dev(1'h0), k);
		u_m.wbyte(8'h00, k);
		for (int i = 0; i < 8; i++) begin
			u_m.wbyte(codes[i], k);
			exp[i] = codes[i];
		end
		u_m.stop();
		u_m.hold(10);
		chk(busy, 1'h0);
		chk_dac();
	endtask
	task automatic t_reserved();
		wr(dev(1'h0), 8'h09, 8'h5A, 1'h0, 1'h1);
		u_m.hold(10);
		chk(busy, 1'h0);
		rd(8'h09, 1);
	endtask
	task automatic t_strap();
		wr(dev(1'h0) ^ 8'h02, 8'h00, 8'hEE, 1'h1, 1'h1);
		chk_dac();
		strap = 1'h1;
		u_m.hold(20);
		wr(8'hE8, 8'h00, 8'hEE, 1'h1, 1'h1);
		wr(8'hEA, 8'h00, 8'h11, 1'h0, 1'h1);
		exp[0] = 8'h11;
		u_m.hold(10);
		chk_dac();
		strap = 1'h0;
		u_m.hold(20);
	endtask
	task automatic t_mode_back();
		wr(dev(1'h0), 8'h08, 8'h00, 1'h0, 1'h1);
		mode = 1'h0;
		u_m.hold(10);
		chk_dac();
		rd(8'h08, 1);
	endtask
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		rst = 1'h1;
		strap = 1'h0;
		mode = 1'h0;
		errors = 0;
		n_checks = 0;
		for (int i = 0; i < 8; i++) exp[i] = 8'h80;
		repeat (20) @(negedge clk);
		rst = 1'h0;
		t_power();
		t_mode0();
		t_ctrl();
		t_burst();
		t_reserved();
		t_strap();
		t_mode_back();
		summarize();
	end
	// about 52k clocks of traffic are expected; leave margin below 95k
	initial begin
		repeat (95000) @(posedge clk);
		errors = errors + 1;
		summarize();
	end
endmodule
`default_nettype wire
